// File: src/icr_top.sv
// Purpose: Interrupt control register with vector table select and edge select.
// Assumes: APB slave, 32-bit data, zero wait states.
// Notes:   External flags are sticky, cleared by writing one.
// What this block does
// RULE1 - Vector select bit 15 set means alternate vector table is used.
// RULE2 - Vector select bit 15 clear, its reset value, means standard table.
// RULE3 - Bit 14 reads one while timed disable is active; writes ignored.
// RULE4 - Bits 2, 1, 0 are read-write polarity selects for external inputs.
// RULE5 - Polarity one detects falling edge; zero detects rising edge.
// RULE6 - A detected selected edge sets that input's request flag.
// RULE7 - Bits 13 to 3 read zero and ignore writes.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module icr_top
  import icr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timed_irq_disable_active,
  input  wire logic [2:0]  ext_irq_pin,
  output logic             alt_vector_table_select,
  output logic [2:0]       ext_irq_request_flag,
  output logic             irq
);
  logic [15:0] interrupt_control_two;
  logic [15:0] ctrl_write;
  logic        alt_table;
  logic        next_alt_table;
  logic [2:0]  edge_polarity;
  logic [2:0]  next_edge_polarity;
  logic [2:0]  irq_mask;
  logic [2:0]  next_irq_mask;
  logic [2:0]  next_request_flag;
  logic [2:0]  edge_hit;
  logic [2:0]  clear_req;
  logic        next_irq;
  logic [31:0] next_prdata;
  logic        setup_phase;
  logic        access_phase;
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic        hit_ctrl;
  logic        hit_flags;
  logic        hit_mask;

  // Compares the bus address with one register offset.
  function automatic logic is_reg(
    input logic [11:0] a,
    input logic [11:0] off
  );
    return a == off;
  endfunction

  // True for the three offsets that hold a register; others answer with an error.
  function automatic logic is_mapped(input logic [11:0] a);
    return is_reg(a, ICR_OFF_CTRL) || is_reg(a, ICR_OFF_FLAGS) || is_reg(a, ICR_OFF_MASK);
  endfunction

  // Builds the software view of the control register from its live fields.
  function automatic logic [15:0] ctrl_word(
    input logic       alt,
    input logic       dis,
    input logic [2:0] pol
  );
    logic [15:0] v;
    v                    = 16'h0000;
    v[ICR_ALT_TABLE_BIT] = alt;
    v[ICR_TIMED_DIS_BIT] = dis;
    v[2:0]               = pol;
    return v;
  endfunction

  // Pads a register image with zeros up to the bus width.
  function automatic logic [31:0] widen_half(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  function automatic logic [31:0] widen_flags(input logic [2:0] v);
    return {29'h0000_0000, v};
  endfunction

  // Bus phase decode; the slave never inserts wait states.
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_ok      = is_mapped(paddr);
  assign hit_ctrl     = is_reg(paddr, ICR_OFF_CTRL);
  assign hit_flags    = is_reg(paddr, ICR_OFF_FLAGS);
  assign hit_mask     = is_reg(paddr, ICR_OFF_MASK);
  assign wr_en        = access_phase & pwrite;
  assign rd_setup     = setup_phase & ~pwrite;
  assign pready       = 1'b1;
  assign pslverr      = access_phase & ~addr_ok;

  // Only the writable fields survive; bits 14 to 3 are never stored.
  assign ctrl_write = pwdata[15:0] & ICR_CTRL_WMASK; // RULE3 RULE7

  always_comb begin
    next_alt_table = alt_table;
    if (wr_en && hit_ctrl) begin
      next_alt_table = ctrl_write[ICR_ALT_TABLE_BIT]; // RULE1
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alt_table <= ICR_CTRL_RESET[ICR_ALT_TABLE_BIT]; // RULE2
    end else begin
      alt_table <= next_alt_table;
    end
  end

  always_comb begin
    next_edge_polarity = edge_polarity;
    if (wr_en && hit_ctrl) begin
      next_edge_polarity = ctrl_write[2:0]; // RULE4
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      edge_polarity <= ICR_CTRL_RESET[2:0];
    end else begin
      edge_polarity <= next_edge_polarity;
    end
  end

  assign alt_vector_table_select = alt_table; // RULE1 RULE2

  // Status bit 14 is taken live from the disable input, never from storage.
  assign interrupt_control_two = ctrl_word(alt_table,
                                           timed_irq_disable_active,
                                           edge_polarity); // RULE3 RULE7

  genvar g;
  generate
    for (g = 0; g < ICR_NUM_EXT; g++) begin : gen_ext
      icr_edge_detect u_edge (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .pin         (ext_irq_pin[g]),
        .falling_sel (edge_polarity[g]),
        .edge_pulse  (edge_hit[g])
      );
    end
  endgenerate

  // A clear takes effect only where software writes a one.
  always_comb begin
    clear_req = 3'h0;
    if (wr_en && hit_flags) begin
      clear_req = pwdata[2:0];
    end
  end

  // Sticky flags; a new edge wins over a simultaneous clear.
  always_comb begin
    next_request_flag = (ext_irq_request_flag & ~clear_req) | edge_hit; // RULE6
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ext_irq_request_flag <= ICR_FLAGS_RESET;
    end else begin
      ext_irq_request_flag <= next_request_flag; // RULE6
    end
  end

  always_comb begin
    next_irq_mask = irq_mask;
    if (wr_en && hit_mask) begin
      next_irq_mask = pwdata[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_mask <= ICR_MASK_RESET;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // The interrupt line follows any unmasked flag one clock later.
  assign next_irq = |(ext_irq_request_flag & irq_mask);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Read data are taken in the setup cycle and stand through the access phase.
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      unique case (paddr)
        ICR_OFF_CTRL: begin
          next_prdata = widen_half(interrupt_control_two); // RULE3 RULE7
        end
        ICR_OFF_FLAGS: begin
          next_prdata = widen_flags(ext_irq_request_flag);
        end
        ICR_OFF_MASK: begin
          next_prdata = widen_flags(irq_mask);
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end
endmodule

// File: src/icr_pkg.sv
// Purpose: Shared constants for the interrupt control and edge select block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses; field positions are bit numbers.
package icr_pkg;
  localparam logic [11:0] ICR_OFF_CTRL      = 12'h000;
  localparam logic [11:0] ICR_OFF_FLAGS     = 12'h004;
  localparam logic [11:0] ICR_OFF_MASK      = 12'h008;
  localparam int          ICR_ALT_TABLE_BIT = 15;
  localparam int          ICR_TIMED_DIS_BIT = 14;
  localparam int          ICR_NUM_EXT       = 3;
  localparam logic [15:0] ICR_CTRL_RESET    = 16'h0000;
  localparam logic [15:0] ICR_CTRL_WMASK    = 16'h8007;
  localparam logic [2:0]  ICR_FLAGS_RESET   = 3'h0;
  localparam logic [2:0]  ICR_MASK_RESET    = 3'h0;
endpackage

// File: src/icr_edge_detect.sv
// Purpose: Synchronise one external interrupt pin and detect the selected edge.
// Assumes: Pin is asynchronous to mclk.
// Notes:   Pulse appears two edges after the pin changes.
`timescale 1ns/1ps
module icr_edge_detect
  import icr_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic pin,
  input  wire logic falling_sel,
  output logic      edge_pulse
);
  logic sync_a;
  logic sync_b;
  logic last;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      last   <= sync_b;
    end
  end

  // Falling edge when the polarity bit is one, rising edge when zero.
  always_comb begin
    edge_pulse = falling_sel ? (last & ~sync_b) : (~last & sync_b); // RULE5
  end
endmodule

// File: testbench/icr_checker.sv
// Purpose: Port assertions for the control block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to icr_top below.
`timescale 1ns/1ps
module icr_checker
  import icr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        irq,
  input wire logic        timed_irq_disable_active,
  input wire logic        alt_vector_table_select,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [2:0]  ext_irq_request_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic ac = psel && penable;
  wire logic flag_wr = ac && pwrite && paddr == ICR_OFF_FLAGS;
  a_flag_sticky: assert property (!flag_wr |=>
    (ext_irq_request_flag & $past(ext_irq_request_flag)) == $past(ext_irq_request_flag))
    else $error("request flag dropped without clear");
  a_ctrl_upper: assert property (ac && !pwrite && paddr == ICR_OFF_CTRL |->
    prdata[31:16] == 16'h0000) else $error("ctrl upper bits not zero");
  a_alt_readback: assert property (ac && !pwrite && paddr == ICR_OFF_CTRL |->
    prdata[15] == $past(alt_vector_table_select)) else $error("ctrl bit 15 read wrong");
  a_alt_write: assert property (ac && pwrite && paddr == ICR_OFF_CTRL |=>
    alt_vector_table_select == $past(pwdata[15])) else $error("alt select wrong");
  a_alt_hold: assert property (!(ac && pwrite) |=>
    $stable(alt_vector_table_select)) else $error("alt select moved");
  a_ctrl_read: assert property (ac && !pwrite && paddr == ICR_OFF_CTRL |->
    prdata[14:3] == {$past(timed_irq_disable_active), 11'h000}) else $error("ctrl read");
  a_irq_cause: assert property (irq |-> $past(|ext_irq_request_flag))
    else $error("irq without flag");
endmodule
bind icr_top icr_checker icr_checker_inst (.mclk, .reset_n, .psel, .penable, .pwrite,
  .irq, .timed_irq_disable_active, .alt_vector_table_select, .paddr, .pwdata, .prdata,
  .ext_irq_request_flag);

// File: testbench/icr_pin_src.sv
// Purpose: External sources on the three interrupt pins.
// Assumes: Pins move just after a clock edge.
// Notes:   Each call flips one pin.
`timescale 1ns/1ps
module icr_pin_src (
  input  wire logic       mclk,
  output logic      [2:0] pin
);
  initial pin = 3'h0;
  task automatic flip(input int n);
    @(posedge mclk) pin[n] <= ~pin[n];
  endtask
endmodule

// File: testbench/icr_tb_top.sv
// Purpose: Self-checking bench for the control block.
// Assumes: Zero wait APB slave.
// Notes:   Integers model ctrl and flags.
`timescale 1ns/1ps
module icr_tb_top
  import icr_pkg::*;
;
  logic        mclk, reset_n, psel, penable, pwrite, tmr_dis, pready, pslverr, alt, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  pin, flag;
  integer      fail_count = 0, samples_checked = 0, cyc = 0, seed = 91, c, f, n, p;
  icr_top icr_top_inst (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timed_irq_disable_active(tmr_dis), .ext_irq_pin(pin),
    .alt_vector_table_select(alt), .ext_irq_request_flag(flag), .irq);
  icr_pin_src icr_pin_src_inst (.mclk, .pin);
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, x);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic end_sim;
    $display("%0d checks %0d fails", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge mclk);
  endtask
  always @(posedge mclk) if (++cyc == 2000) begin
    fail_count++;
    end_sim;
  end
  initial begin
    {reset_n, psel, penable, pwrite, tmr_dis, paddr, pwdata} = '0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    apb(0, ICR_OFF_CTRL, 0);
    chk(r, 0);
    chk(alt, 0);
    apb(0, 12'h0ff0, 0);
    chk(e, 1);
    chk(r, 0);
    repeat (4) begin
      c = $random(seed);
      tmr_dis <= c[20];
      apb(1, ICR_OFF_CTRL, c);
      chk(alt, c[15]);
      apb(0, ICR_OFF_CTRL, 0);
      chk(r, (c & 32'h0000_8007) | {tmr_dis, 14'h0000});
      chk(e, 0);
    end
    apb(1, ICR_OFF_MASK, 7);
    apb(0, ICR_OFF_MASK, 0);
    chk(r, 7);
    for (n = 0; n < 3; n++) for (p = 0; p < 2; p++) begin
      apb(1, ICR_OFF_CTRL, p << n);
      apb(1, ICR_OFF_FLAGS, 7);
      f = 0;
      repeat (2) begin
        icr_pin_src_inst.flip(n);
        repeat (7) @(posedge mclk);
        f = f | ((pin[n] ^ p) << n);
        chk(flag, f);
        chk(irq, f != 0);
      end
      apb(0, ICR_OFF_FLAGS, 0);
      chk(r, f);
    end
    apb(1, ICR_OFF_MASK, 0);
    repeat (2) @(posedge mclk);
    chk(irq, 0);
    apb(1, ICR_OFF_FLAGS, 7);
    chk(flag, 0);
    apb(1, ICR_OFF_CTRL, 32'h0000_8007);
    apb(1, ICR_OFF_MASK, 7);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    chk(alt, 0);
    apb(0, ICR_OFF_CTRL, 0);
    chk(r, {tmr_dis, 14'h0000});
    apb(0, ICR_OFF_MASK, 0);
    chk(r, 0);
    end_sim;
  end
endmodule
